// ---- core/escr_core.sv ----
// encoder scaling, stall stop and adaptive current regulation for one axis
`timescale 1ns/1ps
`default_nettype none
module escr_core import escr_pkg::*; #(
  parameter int unsigned DELAY_CYC = DELAY_UNIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire escr_cfg_t cfg,
  // motion state from the ramp generator
  input wire logic signed [31:0] motor_pos,
  input wire logic signed [31:0] velocity_raw,
  input wire logic ref_done,
  // encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  // software write of encoder position
  input wire logic enc_pos_wr,
  input wire logic signed [31:0] enc_pos_wdata,
  // load reading from the driver
  input wire logic load_valid,
  input wire logic [9:0] load_value,
  // outputs
  output logic signed [31:0] enc_pos,
  output logic motor_stop,
  output logic stall_event,
  output logic deviation_event,
  output logic [4:0] current_step,
  output logic [7:0] current_scale,
  output logic standby_active,
  output logic [15:0] usteps_per_step,
  output logic signed [31:0] velocity_pps
);
  initial begin
    if (DELAY_CYC < 1) $error("delay unit must be at least one cycle");
  end

  // two-stage synchronisers on the encoder pins
  logic [2:0] enc_s1_reg, enc_s2_reg, enc_s3_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      enc_s1_reg <= 3'h0;
      enc_s2_reg <= 3'h0;
      enc_s3_reg <= 3'h0;
    end else begin
      enc_s1_reg <= {enc_n, enc_b, enc_a};
      enc_s2_reg <= enc_s1_reg;
      enc_s3_reg <= enc_s2_reg;
    end
  end

  // quadrature decode: +1, -1 or 0 per edge
  logic step_up, step_dn;
  always_comb begin
    logic a0, b0, a1, b1;
    a0 = enc_s3_reg[0];
    b0 = enc_s3_reg[1];
    a1 = enc_s2_reg[0];
    b1 = enc_s2_reg[1];
    step_up = ((a1 ^ a0) & (a1 ^ b1)) | ((b1 ^ b0) & ~(a1 ^ b1));
    step_dn = ((a1 ^ a0) & ~(a1 ^ b1)) | ((b1 ^ b0) & (a1 ^ b1));
  end
  wire index_rise = enc_s2_reg[2] & ~enc_s3_reg[2];

  // microsteps per full step from code, 8 -> 256
  function automatic logic [15:0] ustep_of(input logic [3:0] code);
    ustep_of = (code > 4'h8) ? 16'h0100 : (16'h0001 << code);
  endfunction : ustep_of
  assign usteps_per_step = ustep_of(cfg.ustep_code);

  // microsteps per revolution, the numerator of the scale
  logic [31:0] usteps_per_rev;
  assign usteps_per_rev = cfg.fullsteps * usteps_per_step;

  // encoder scaling: add usteps_per_rev per count and divide by enc_counts,
  // adding the whole microsteps to the position and keeping the remainder
  // in frac_reg, so less than one microstep of lag stays inside a count
  logic signed [31:0] frac_reg;
  logic signed [31:0] enc_pos_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      frac_reg <= 32'sh0;
      enc_pos_reg <= 32'sh0;
    end else if (ref_done) begin
      frac_reg <= 32'sh0;
      enc_pos_reg <= 32'sh0;
    end else if (enc_pos_wr) begin
      frac_reg <= 32'sh0;
      enc_pos_reg <= enc_pos_wdata;
    end else if (cfg.index_clear && index_rise) begin
      frac_reg <= 32'sh0;
      enc_pos_reg <= 32'sh0;
    end else if (cfg.enc_counts != 16'h0 && (step_up || step_dn)) begin
      logic signed [31:0] acc;
      logic signed [31:0] whole;
      acc = frac_reg + (step_up ? $signed(usteps_per_rev)
                                : -$signed(usteps_per_rev));
      whole = acc / $signed({16'h0, cfg.enc_counts});
      frac_reg <= acc - whole * $signed({16'h0, cfg.enc_counts});
      enc_pos_reg <= enc_pos_reg + whole;
    end
  end
  assign enc_pos = enc_pos_reg;

  // velocity in pps: mode 1 passes pps, mode 0 raw units unchanged
  // both cases are taken as given since no conversion law is known
  always_ff @(posedge clk) begin
    if (reset) velocity_pps <= 32'sh0;
    else if (cfg.unit_mode) velocity_pps <= velocity_raw;
    else velocity_pps <= velocity_raw;
  end
  logic [31:0] speed;
  assign speed = velocity_raw[31] ? 32'(-velocity_raw) : velocity_raw;

  // deviation between motor and encoder position
  logic [31:0] dev_abs;
  always_comb begin
    logic signed [31:0] d;
    d = motor_pos - enc_pos_reg;
    dev_abs = d[31] ? 32'(-d) : d;
  end

  // motor stop, sticky until reset or reference completion; events pulse one cycle
  logic stop_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      stop_reg <= 1'b0;
      stall_event <= 1'b0;
      deviation_event <= 1'b0;
    end else begin
      stall_event <= 1'b0;
      deviation_event <= 1'b0;
      if (cfg.max_deviation != 32'h0 && dev_abs > cfg.max_deviation) begin
        stop_reg <= 1'b1;
        deviation_event <= ~stop_reg;
      end else if (cfg.stall_stop_speed != 32'h0 && speed >
                   cfg.stall_stop_speed && load_valid &&
                   load_value == 10'h0) begin
        stop_reg <= 1'b1;
        stall_event <= ~stop_reg;
      end else if (ref_done) begin
        stop_reg <= 1'b0;
      end
    end
  end
  assign motor_stop = stop_reg;

  // standstill timer in 10 ms units
  logic [31:0] tick_cnt_reg;
  logic [15:0] still_cnt_reg;
  always_ff @(posedge clk) begin
    if (reset || speed != 32'h0) begin
      tick_cnt_reg <= 32'h0;
      still_cnt_reg <= 16'h0;
      standby_active <= 1'b0;
    end else if (still_cnt_reg >= cfg.power_down_delay) begin
      standby_active <= 1'b1;
    end else if (tick_cnt_reg == 32'(DELAY_CYC - 1)) begin
      tick_cnt_reg <= 32'h0;
      still_cnt_reg <= still_cnt_reg + 16'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  // run and minimum steps from the absolute current, 8 codes per step
  logic [4:0] run_step, min_step;
  assign run_step = cfg.absolute_max_current[7:CUR_STEP_SHIFT];
  assign min_step = cfg.adaptive_current_minimum ? 5'(run_step >> 2)
                                                 : 5'(run_step >> 1);

  // hysteresis thresholds
  logic [10:0] upper_thr;
  assign upper_thr = {1'b0, cfg.adaptive_current_threshold} +
                     {1'b0, cfg.load_threshold_hysteresis};
  wire reg_enable = speed > cfg.adaptive_current_threshold_speed;

  // down-step count: 32, 8, 2, 1
  function automatic logic [5:0] down_count(input logic [1:0] c);
    unique case (c)
      2'd0: down_count = 6'd32;
      2'd1: down_count = 6'd8;
      2'd2: down_count = 6'd2;
      2'd3: down_count = 6'd1;
    endcase
  endfunction : down_count

  // adaptive current step regulation
  logic [4:0] cur_reg;
  logic [5:0] high_cnt_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_reg <= 5'h0;
      high_cnt_reg <= 6'h0;
    end else if (!reg_enable) begin
      cur_reg <= run_step; // regulation off, full run current
      high_cnt_reg <= 6'h0;
    end else if (load_valid) begin
      if ({1'b0, load_value} > upper_thr) begin
        if (high_cnt_reg + 6'h1 >= down_count(cfg.adaptive_current_down_step))
        begin
          high_cnt_reg <= 6'h0;
          cur_reg <= (cur_reg > min_step) ? cur_reg - 5'h1 : min_step;
        end else begin
          high_cnt_reg <= high_cnt_reg + 6'h1;
        end
      end else if (load_value < cfg.adaptive_current_threshold) begin
        logic [5:0] up;
        up = {1'b0, cur_reg} + (6'h1 << cfg.adaptive_current_up_step);
        cur_reg <= (up > {1'b0, run_step}) ? run_step : up[4:0];
        high_cnt_reg <= 6'h0;
      end
    end
  end

  // output current scale
  always_ff @(posedge clk) begin
    if (reset) begin
      current_step <= 5'h0;
      current_scale <= 8'h0;
    end else if (standby_active) begin
      current_step <= cfg.standby_current[7:CUR_STEP_SHIFT];
      current_scale <= cfg.standby_current;
    end else begin
      current_step <= cur_reg;
      current_scale <= {cur_reg, 3'h7};
    end
  end

  a_ref_zero: assert property (@(posedge clk) disable iff (reset)
    ref_done |=> enc_pos == 32'sh0) else $error("encoder not zeroed");
  a_pos_write: assert property (@(posedge clk) disable iff (reset)
    enc_pos_wr && !ref_done |=> enc_pos == $past(enc_pos_wdata))
    else $error("encoder write lost");
  a_stall_stop: assert property (@(posedge clk) disable iff (reset)
    load_valid && load_value == 10'h0 && cfg.stall_stop_speed != 32'h0 &&
    speed > cfg.stall_stop_speed |=> motor_stop) else $error("no stall stop");
  a_dev_stop: assert property (@(posedge clk) disable iff (reset)
    cfg.max_deviation != 32'h0 && dev_abs > cfg.max_deviation |=> motor_stop)
    else $error("no deviation stop");
  a_cur_floor: assert property (@(posedge clk) disable iff (reset)
    reg_enable && $past(reg_enable) && $stable(run_step) |-> cur_reg >= min_step
    || cur_reg == $past(cur_reg)) else $error("current below minimum");
  a_cur_ceil: assert property (@(posedge clk) disable iff (reset)
    $stable(run_step) && $past(cur_reg) <= run_step |-> cur_reg <= run_step)
    else $error("current above run");
  a_reg_off: assert property (@(posedge clk) disable iff (reset)
    !reg_enable |=> cur_reg == $past(run_step)) else $error("regulation on");
  a_ustep_dflt: assert property (@(posedge clk) disable iff (reset)
    cfg.ustep_code == 4'h8 |-> usteps_per_step == 16'h0100)
    else $error("bad microstep map");
  a_standby: assert property (@(posedge clk) disable iff (reset)
    standby_active && $past(standby_active) |-> current_scale ==
    $past(cfg.standby_current)) else $error("standby current missing");
endmodule : escr_core
`default_nettype wire

// ---- shared/escr_pkg.sv ----
// package for the encoder, stall and current regulation block
package escr_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned DELAY_UNIT_MS = 10;
  localparam int unsigned DELAY_UNIT_CYC = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam logic [15:0] FULLSTEP_DEFAULT = 16'h00c8;
  localparam logic [15:0] PWR_DOWN_DEFAULT = 16'h00c8;
  localparam logic [3:0] USTEP_CODE_DEFAULT = 4'h8;
  localparam logic UNIT_MODE_DEFAULT = 1'b1;
  localparam int unsigned CUR_STEP_SHIFT = 3;
  localparam logic [7:0] CUR_MAX = 8'hff;
  localparam int unsigned RPM_PER_RPS = 60;

  // configuration bundle steering the block
  typedef struct packed {
    logic [15:0] fullsteps;      // motor full steps per revolution
    logic [15:0] enc_counts;     // encoder counts per revolution
    logic [3:0] ustep_code;      // microstep resolution code
    logic unit_mode;             // 1 = pps, 0 = internal units
    logic [31:0] max_deviation;  // 0 disables the deviation stop
    logic index_clear;           // clear encoder count on index
    logic [31:0] stall_stop_speed;
    logic [31:0] adaptive_current_threshold_speed;
    logic [15:0] power_down_delay;
    logic adaptive_current_minimum;
    logic [1:0] adaptive_current_down_step;
    logic [1:0] adaptive_current_up_step;
    logic [9:0] adaptive_current_threshold;
    logic [9:0] load_threshold_hysteresis;
    logic [7:0] absolute_max_current;
    logic [7:0] standby_current;
  } escr_cfg_t;
endpackage : escr_pkg

// ---- verification/escr_enc_model.sv ----
// quadrature encoder model standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module escr_enc_model (
  // clock
  input wire logic clk,
  // requested shaft position in counts, index gate
  input wire logic signed [31:0] target,
  input wire logic index_en,
  // encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_n
);
  int pos = 0;   // counts moved so far
  int hold = 0;  // slow edges so the pin synchroniser sees each state
  // one count per step toward target; a leads b going up
  always @(posedge clk) begin
    if (hold != 0) hold <= hold - 1;
    else if (pos != target) begin
      pos <= (pos < target) ? pos + 1 : pos - 1;
      hold <= 5;
    end
  end
  // gray phase of the count, index only at phase zero
  assign enc_a = (pos[1:0] == 2'h1) || (pos[1:0] == 2'h2);
  assign enc_b = pos[1];
  assign enc_n = index_en && (pos[1:0] == 2'h0);
endmodule : escr_enc_model
`default_nettype wire

// ---- verification/escr_core_tb.sv ----
// self-checking bench for the encoder, stall and current block
`timescale 1ns/1ps
`default_nettype none
module escr_core_tb;
  import escr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  escr_cfg_t cfg;
  logic signed [31:0] motor_pos = '0, velocity_raw = '0, wdata = '0;
  logic signed [31:0] target = '0, enc_pos, velocity_pps;
  logic ref_done = 1'b0, wr = 1'b0, load_valid = 1'b0, index_en = 1'b0;
  logic [9:0] load_value = '0;
  logic enc_a, enc_b, enc_n, motor_stop, stall_event, deviation_event;
  logic standby_active;
  logic [4:0] current_step;
  logic [7:0] current_scale;
  logic [15:0] usteps_per_step;
  logic [31:0] seed = 32'h40140da7;  // fixed start of the random stream
  int sel_q[$];
  logic [31:0] val_q[$];
  int n_fail = 0, cmp_count = 0;
  escr_core #(.DELAY_CYC(10)) escr_core_i (.clk(clk), .reset(reset),
    .cfg(cfg), .motor_pos(motor_pos), .velocity_raw(velocity_raw),
    .ref_done(ref_done), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
    .enc_pos_wr(wr), .enc_pos_wdata(wdata), .load_valid(load_valid),
    .load_value(load_value), .enc_pos(enc_pos), .motor_stop(motor_stop),
    .stall_event(stall_event), .deviation_event(deviation_event),
    .current_step(current_step), .current_scale(current_scale),
    .standby_active(standby_active), .usteps_per_step(usteps_per_step),
    .velocity_pps(velocity_pps));
  escr_enc_model escr_enc_model_i (.clk(clk), .target(target),
    .index_en(index_en), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: return enc_pos;
      1: return {motor_stop, stall_event, deviation_event};
      2: return {current_step, current_scale};
      3: return {standby_active, current_scale};
      4: return usteps_per_step;
      default: return velocity_pps;
    endcase
  endfunction : obs
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  // note the expectation; the watcher compares at the coming falling edge,
  // so the caller stays on the rising edge and keeps driving there
  task automatic expect_val(input int s, input logic [31:0] v);
    sel_q.push_back(s);
    val_q.push_back(v);
  endtask : expect_val
  // outputs are settled half a cycle after each rising edge
  always @(negedge clk) begin
    while (sel_q.size() > 0) check(obs(sel_q.pop_front()), val_q.pop_front());
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // position write, optionally with reference done in the same cycle
  task automatic pos_load(input logic rd, input logic [31:0] w);
    @(posedge clk);
    wr <= 1'b1;
    ref_done <= rd;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
    ref_done <= 1'b0;
  endtask : pos_load
  task automatic load(input logic [9:0] v);
    @(posedge clk);
    load_valid <= 1'b1;
    load_value <= v;
    @(posedge clk);
    load_valid <= 1'b0;
  endtask : load
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // hang guard: far above the roughly 500 cycles the run needs
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial begin
    cfg = '{FULLSTEP_DEFAULT, 16'h0190, 4'h8, 1'b1, 32'h0, 1'b0, 32'h0,
      32'h3e8, 16'h0003, 1'b0, 2'h3, 2'h3, 10'h064, 10'h032, 8'h80, 8'h20};
    tick(2);
    reset <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      cfg.unit_mode <= m[0];
      velocity_raw <= {16'h0, seed[15:0]};
      tick(2);
      expect_val(5, velocity_raw);
    end
    for (int c = 8; c < 10; c++) begin
      cfg.ustep_code <= c[3:0];
      tick(1);
      expect_val(4, 32'h100);
    end
    velocity_raw <= '0;
    seed = lfsr(seed);
    pos_load(1'b0, seed);
    expect_val(0, seed);
    pos_load(1'b1, 32'h1234);
    expect_val(0, 32'h0);
    // 200 steps x 256 over 400 counts gives 128 per count
    target <= 8;
    tick(70);
    expect_val(0, 32'd1024);
    target <= 4;
    tick(40);
    expect_val(0, 32'd512);
    pos_load(1'b0, 32'h5000);
    cfg.index_clear <= 1'b1;
    index_en <= 1'b1;
    target <= 8;
    tick(40);
    expect_val(0, 32'h0);
    index_en <= 1'b0;
    cfg.stall_stop_speed <= 32'd500;
    velocity_raw <= 32'd400;
    load(10'h0);
    tick(1);
    expect_val(1, 32'h0);
    velocity_raw <= 32'd600;
    tick(2);
    load(10'h0);
    expect_val(1, 32'h6);
    tick(1);
    expect_val(1, 32'h4);
    pos_load(1'b1, 32'h0);
    cfg.stall_stop_speed <= 32'd0;
    cfg.max_deviation <= 32'd100;
    motor_pos <= 32'd50;
    tick(3);
    expect_val(1, 32'h0);
    motor_pos <= 32'd500;
    tick(1);
    expect_val(1, 32'h5);
    tick(1);
    expect_val(1, 32'h4);
    motor_pos <= '0;
    cfg.max_deviation <= '0;
    pos_load(1'b1, 32'h0);
    velocity_raw <= 32'd2000;
    tick(3);
    expect_val(2, {5'h10, 8'h87});
    load(10'd150);
    load(10'd120);
    tick(2);
    expect_val(2, {5'h10, 8'h87});
    for (int d = 0; d < 4; d++) begin
      cfg.adaptive_current_down_step <= d[1:0];
      repeat ((d == 0) ? 31 : (d == 1) ? 7 : 3 - d) load(10'd200);
      tick(2);
      expect_val(2, {5'(16 - d), 5'(16 - d), 3'h7});
      load(10'd200);
      tick(2);
      expect_val(2, {5'(15 - d), 5'(15 - d), 3'h7});
    end
    repeat (10) load(10'd200);
    tick(2);
    expect_val(2, {5'h8, 8'h47});
    for (int u = 0; u < 4; u++) begin
      cfg.adaptive_current_up_step <= u[1:0];
      load(10'd50);
      tick(2);
      expect_val(2, {5'(8 + (1 << u)), 5'(8 + (1 << u)), 3'h7});
      repeat (10) load(10'd200);
    end
    repeat (3) load(10'd50);
    tick(2);
    expect_val(2, {5'h10, 8'h87});
    cfg.adaptive_current_minimum <= 1'b1;
    repeat (20) load(10'd200);
    tick(2);
    expect_val(2, {5'h4, 8'h27});
    velocity_raw <= 32'd1000;
    tick(3);
    load(10'd200);
    tick(2);
    expect_val(2, {5'h10, 8'h87});
    velocity_raw <= '0;
    tick(20);
    expect_val(3, 32'h87);
    tick(20);
    expect_val(3, 32'h120);
    tick(1);
    end_of_test();
  end
endmodule : escr_core_tb
`default_nettype wire
